//--- logic/drs_pkg.sv
// Purpose: Shared constants and types for the display hardware reset sequencer
// Assumes: 20 MHz core clock
// Notes: Times are kept in their own units; cycle counts derive from them
package drs_pkg;

    localparam longint unsigned CLK_HZ = 64'd20000000;
    localparam longint unsigned US_PER_S = 64'd1000000;
    localparam longint unsigned MS_PER_S = 64'd1000;

    // Reset pin pulse widths (us)
    localparam longint unsigned REJECT_US = 64'd5;
    localparam longint unsigned FULL_RESET_US = 64'd9;
    // Least spike width that still changes the filtered level, rounded up
    localparam int unsigned FILTER_CYC =
        int'((REJECT_US * CLK_HZ + US_PER_S - 64'd1) / US_PER_S);

    // Release interval limits and host waits (ms)
    localparam longint unsigned RT_SLEEP_MS = 64'd5;
    localparam longint unsigned RT_AWAKE_MS = 64'd120;
    localparam longint unsigned CMD_WAIT_MS = 64'd5;
    localparam longint unsigned WAKE_WAIT_MS = 64'd120;
    localparam longint unsigned BLANK_SEQ_MS = 64'd20;

    localparam int unsigned CMD_WAIT_CYC =
        int'((CMD_WAIT_MS * CLK_HZ + MS_PER_S - 64'd1) / MS_PER_S);
    localparam int unsigned WAKE_WAIT_CYC =
        int'((WAKE_WAIT_MS * CLK_HZ + MS_PER_S - 64'd1) / MS_PER_S);
    // Blanking is a longest time, so it rounds down
    localparam int unsigned BLANK_SEQ_CYC = int'((BLANK_SEQ_MS * CLK_HZ) / MS_PER_S);

    localparam int CNT_W = 22;
    localparam int FILT_W = 8;

    // Settings reloaded from nonvolatile storage
    localparam int NVM_WORDS = 4;
    localparam logic [1:0] NVM_LAST = 2'h3;
    localparam logic [1:0] NVM_IDX_CVS = 2'h3;
    localparam logic [7:0] WAKE_CMD_DEFAULT = 8'h01;
    localparam logic [7:0] SET_RESET_VAL = 8'h00;

    typedef enum logic [1:0] {ST_HELD, ST_LOAD, ST_SETTLE, ST_RUN} drs_state_e;

    typedef struct packed {
        logic [7:0] common_voltage_setting;
        logic [7:0] id3;
        logic [7:0] id2;
        logic [7:0] id1;
    } drs_settings_s;

    typedef struct packed {
        logic rd;
        logic [1:0] addr;
    } drs_nvm_req_s;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } drs_cmd_s;

endpackage

//--- logic/drs_deglitch.sv
// Purpose: Symmetric spike filter for a synchronised level
// Assumes: Input already synchronised to clk
// Notes: Level changes only after holding HOLD_CYC cycles at the new value
module drs_deglitch #(
    parameter int unsigned HOLD_CYC = drs_pkg::FILTER_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Levels
    input wire logic raw_lvl,
    output logic filt_lvl
);

    typedef struct packed {
        logic lvl;
        logic [drs_pkg::FILT_W-1:0] cnt;
    } drs_filt_s;

    drs_filt_s st_ff;
    drs_filt_s nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        if (raw_lvl == st_ff.lvl)
        begin
            nxt_st.cnt = '0;
        end
        else if (st_ff.cnt == drs_pkg::FILT_W'(HOLD_CYC - 1))
        begin
            nxt_st.lvl = raw_lvl;
            nxt_st.cnt = '0;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + drs_pkg::FILT_W'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign filt_lvl = st_ff.lvl;

endmodule

//--- logic/drs_top.sv
// Purpose: Hardware reset sequencer of a display controller
// Assumes: Host drives the reset pin asynchronously; storage answers reads
// Notes: Long counts are parameters so simulation can shorten them

// Functional notes
// - Lows under 5 us rejected; lows over 9 us reset fully.
// - Brief high spikes during a held reset do not end it.
// - Every release reloads ID bytes and common voltage from storage.
// - Reset from low-power state finishes its release within 5 ms.
// - Reset from awake state may take up to 120 ms.
// - Display blanked during reset; blank sequence when awake, then defaults.
module drs_top #(
    parameter int unsigned CMD_WAIT_CYC = drs_pkg::CMD_WAIT_CYC,
    parameter int unsigned WAKE_WAIT_CYC = drs_pkg::WAKE_WAIT_CYC,
    parameter int unsigned BLANK_SEQ_CYC = drs_pkg::BLANK_SEQ_CYC,
    parameter logic [7:0] WAKE_CMD = drs_pkg::WAKE_CMD_DEFAULT
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // Reset pin from host
    input wire logic HW_RESET_N_INPUT,
    // Controller power state
    input wire logic SLEEP_IN_MODE,
    // Host commands
    input wire drs_pkg::drs_cmd_s CMD_IN,
    output drs_pkg::drs_cmd_s CMD_FWD,
    output logic CMD_DROP,
    // Nonvolatile storage read port
    output drs_pkg::drs_nvm_req_s NVM_REQ,
    input wire logic NVM_RD_VALID,
    input wire logic [7:0] NVM_RD_DATA,
    // Status and settings
    output logic BUSY,
    output logic DISPLAY_BLANK,
    output logic CTRL_RESET,
    output drs_pkg::drs_settings_s SETTINGS
);

    typedef struct packed {
        logic pin_s1;
        logic pin_s2;
        drs_pkg::drs_state_e state;
        logic [drs_pkg::CNT_W-1:0] rel_cnt;
        logic [drs_pkg::CNT_W-1:0] blank_cnt;
        logic blank_done;
        logic [1:0] nvm_idx;
        logic [drs_pkg::NVM_WORDS-1:0][7:0] set;
        drs_pkg::drs_nvm_req_s nvm;
        drs_pkg::drs_cmd_s fwd;
        logic drop;
        logic busy;
        logic blank;
        logic ctrl_rst;
    } drs_top_s;

    drs_top_s st_ff;
    drs_top_s nxt_st;
    logic rst_low;

    // Pin polarity flipped so the filter sees reset-active as high
    drs_deglitch #(
        .HOLD_CYC(drs_pkg::FILTER_CYC)
    ) u_deglitch (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .raw_lvl(~st_ff.pin_s2),
        .filt_lvl(rst_low)
    );

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.pin_s1 = HW_RESET_N_INPUT;
        nxt_st.pin_s2 = st_ff.pin_s1;
        nxt_st.nvm.rd = 1'b0;
        nxt_st.fwd.valid = 1'b0;
        nxt_st.drop = 1'b0;

        // Release timer saturates at the wake wait
        if (st_ff.rel_cnt < drs_pkg::CNT_W'(WAKE_WAIT_CYC))
        begin
            nxt_st.rel_cnt = st_ff.rel_cnt + drs_pkg::CNT_W'(1);
        end

        // Blanking sequence runs across hold and release
        if (!st_ff.blank_done)
        begin
            if (st_ff.blank_cnt >= drs_pkg::CNT_W'(BLANK_SEQ_CYC - 1))
            begin
                nxt_st.blank_done = 1'b1;
            end
            else
            begin
                nxt_st.blank_cnt = st_ff.blank_cnt + drs_pkg::CNT_W'(1);
            end
        end

        unique case (st_ff.state)
            drs_pkg::ST_HELD:
            begin
                if (!rst_low)
                begin
                    nxt_st.state = drs_pkg::ST_LOAD;
                    nxt_st.ctrl_rst = 1'b0;
                    nxt_st.rel_cnt = '0;
                    nxt_st.nvm_idx = '0;
                    nxt_st.nvm.rd = 1'b1;
                    nxt_st.nvm.addr = '0;
                end
            end
            drs_pkg::ST_LOAD:
            begin
                if (NVM_RD_VALID)
                begin
                    nxt_st.set[st_ff.nvm_idx] = NVM_RD_DATA;
                    if (st_ff.nvm_idx == drs_pkg::NVM_LAST)
                    begin
                        nxt_st.state = drs_pkg::ST_SETTLE;
                    end
                    else
                    begin
                        nxt_st.nvm_idx = st_ff.nvm_idx + 2'h1;
                        nxt_st.nvm.rd = 1'b1;
                        nxt_st.nvm.addr = st_ff.nvm_idx + 2'h1;
                    end
                end
            end
            drs_pkg::ST_SETTLE:
            begin
                // Busy ends 5 ms after release, and if awake not before blanking ends
                if (st_ff.rel_cnt >= drs_pkg::CNT_W'(CMD_WAIT_CYC) && st_ff.blank_done)
                begin
                    nxt_st.state = drs_pkg::ST_RUN;
                    nxt_st.busy = 1'b0;
                end
            end
            drs_pkg::ST_RUN:
            begin
                if (CMD_IN.valid)
                begin
                    if (CMD_IN.code == WAKE_CMD
                        && st_ff.rel_cnt < drs_pkg::CNT_W'(WAKE_WAIT_CYC))
                    begin
                        nxt_st.drop = 1'b1;
                    end
                    else
                    begin
                        nxt_st.fwd = CMD_IN;
                        if (CMD_IN.code == WAKE_CMD)
                        begin
                            nxt_st.blank = 1'b0;
                        end
                    end
                end
            end
        endcase

        // Commands refused while busy
        if (st_ff.state != drs_pkg::ST_RUN && CMD_IN.valid)
        begin
            nxt_st.drop = 1'b1;
        end

        // Qualified reset from any state restarts the sequence
        if (rst_low && st_ff.state != drs_pkg::ST_HELD)
        begin
            nxt_st.state = drs_pkg::ST_HELD;
            nxt_st.busy = 1'b1;
            nxt_st.blank = 1'b1;
            nxt_st.ctrl_rst = 1'b1;
            nxt_st.nvm.rd = 1'b0;
            nxt_st.fwd.valid = 1'b0;
            // Command caught by the reset is refused, not lost
            nxt_st.drop = CMD_IN.valid;
            if (st_ff.state == drs_pkg::ST_RUN)
            begin
                nxt_st.blank_cnt = '0;
                nxt_st.blank_done = SLEEP_IN_MODE;
            end
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            // Power-on behaves as a reset released from low-power state
            st_ff <= '{
                pin_s1: 1'b1,
                pin_s2: 1'b1,
                state: drs_pkg::ST_HELD,
                rel_cnt: '0,
                blank_cnt: '0,
                blank_done: 1'b1,
                nvm_idx: '0,
                set: {drs_pkg::NVM_WORDS{drs_pkg::SET_RESET_VAL}},
                nvm: '0,
                fwd: '0,
                drop: 1'b0,
                busy: 1'b1,
                blank: 1'b1,
                ctrl_rst: 1'b1
            };
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign CMD_FWD = st_ff.fwd;
    assign CMD_DROP = st_ff.drop;
    assign NVM_REQ = st_ff.nvm;
    assign BUSY = st_ff.busy;
    assign DISPLAY_BLANK = st_ff.blank;
    assign CTRL_RESET = st_ff.ctrl_rst;
    assign SETTINGS = '{
        common_voltage_setting: st_ff.set[drs_pkg::NVM_IDX_CVS],
        id3: st_ff.set[2],
        id2: st_ff.set[1],
        id1: st_ff.set[0]
    };

endmodule

//--- tb/drs_chk.sv
// Purpose: Port assertions for drs_top
// Assumes: One clock domain, reset synchronous and active high
// Notes: Pin run lengths saturate at 255
module drs_chk #(
    parameter int unsigned CMD_WAIT_CYC = 50,
    parameter int unsigned WAKE_WAIT_CYC = 200,
    parameter logic [7:0] WAKE_CMD = 8'h01
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // Watched ports
    input wire logic HW_RESET_N_INPUT,
    input wire drs_pkg::drs_cmd_s CMD_IN,
    input wire drs_pkg::drs_cmd_s CMD_FWD,
    input wire logic CMD_DROP,
    input wire drs_pkg::drs_nvm_req_s NVM_REQ,
    input wire logic BUSY,
    input wire logic DISPLAY_BLANK,
    input wire logic CTRL_RESET
);
    logic [7:0] lo_ff;
    logic [7:0] hi_ff;
    logic [drs_pkg::CNT_W-1:0] rel_ff;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    // Runs of low and high pin samples, cycles since reset released
    always_ff @(posedge CORE_CLK)
    begin
        lo_ff <= SYS_RST || HW_RESET_N_INPUT ? 8'h00 : lo_ff + {7'h00, lo_ff != 8'hff};
        hi_ff <= SYS_RST ? 8'hff : HW_RESET_N_INPUT ? hi_ff + {7'h00, hi_ff != 8'hff} : 8'h00;
        rel_ff <= SYS_RST || CTRL_RESET ? '0 : rel_ff + drs_pkg::CNT_W'(!(&rel_ff));
    end
    sequence s_release;
        $fell(CTRL_RESET);
    endsequence
    sequence s_read_first;
        ##[0:2] (NVM_REQ.rd && NVM_REQ.addr == 2'h0);
    endsequence
    // Run length taken before the pin may already have gone back high
    a_short_reject: assert property ($rose(CTRL_RESET) |-> $past(lo_ff, 3) >= 8'h64)
        else $error("reset from short low");
    a_full_reset: assert property (lo_ff == 8'h6e |-> CTRL_RESET && BUSY && DISPLAY_BLANK)
        else $error("long low not reset");
    a_spike_hold: assert property ($fell(CTRL_RESET) |-> $past(hi_ff, 3) >= 8'h64)
        else $error("reset ended by spike");
    a_reload_start: assert property (s_release |-> s_read_first)
        else $error("no reload on release");
    a_busy_wait: assert property ($fell(BUSY) |-> rel_ff >= CMD_WAIT_CYC)
        else $error("busy fell early");
    a_busy_drop: assert property (CMD_IN.valid && BUSY |=> CMD_DROP && !CMD_FWD.valid)
        else $error("command taken while busy");
    a_early_wake: assert property (CMD_IN.valid && CMD_IN.code == WAKE_CMD
        && rel_ff + drs_pkg::CNT_W'(2) < WAKE_WAIT_CYC |=> CMD_DROP && !CMD_FWD.valid)
        else $error("early wake taken");
endmodule

bind drs_top drs_chk #(.CMD_WAIT_CYC(CMD_WAIT_CYC), .WAKE_WAIT_CYC(WAKE_WAIT_CYC),
    .WAKE_CMD(WAKE_CMD)) u_chk (
    .CORE_CLK(CORE_CLK),
    .SYS_RST(SYS_RST),
    .HW_RESET_N_INPUT(HW_RESET_N_INPUT),
    .CMD_IN(CMD_IN),
    .CMD_FWD(CMD_FWD),
    .CMD_DROP(CMD_DROP),
    .NVM_REQ(NVM_REQ),
    .BUSY(BUSY),
    .DISPLAY_BLANK(DISPLAY_BLANK),
    .CTRL_RESET(CTRL_RESET)
);

//--- tb/drs_host_mdl.sv
// Purpose: Host reset pin and settings storage facing drs_top
// Assumes: Changes on the falling clock edge
// Notes: Storage data toggles while not valid
module drs_host_mdl (
    // Clock and pace
    input wire logic clk,
    input wire logic slow,
    // Storage read port
    input wire drs_pkg::drs_nvm_req_s nvm_req,
    output logic nvm_valid,
    output logic [7:0] nvm_data,
    // Reset pin
    output logic pin_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] base = 8'h00;
    int lag = -1;
    initial
    begin
        nvm_valid = 1'b0;
        nvm_data = 8'h00;
        pin_n = 1'b1;
    end
    // Answer each read at once or after three idle cycles
    always @(negedge clk)
    begin
        if (nvm_req.rd)
            lag = slow ? 3 : 0;
        nvm_valid <= lag == 0;
        nvm_data <= lag == 0 ? base + {6'h00, nvm_req.addr} : ~nvm_data;
        if (lag >= 0)
            lag--;
    end
    // Low for lo cycles; nonzero hi adds a spike, then 50 more low
    task automatic pulse(input int lo, input int hi);
        @(negedge clk);
        pin_n = 1'b0;
        repeat (lo) @(negedge clk);
        if (hi > 0)
        begin
            pin_n = 1'b1;
            repeat (hi) @(negedge clk);
            pin_n = 1'b0;
            repeat (50) @(negedge clk);
        end
        pin_n = 1'b1;
    endtask
endmodule

//--- tb/tb.sv
// Purpose: Self-checking bench for drs_top
// Assumes: Long counts shortened by parameters
// Notes: Inputs change on the falling edge
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CW = 50;
    localparam int WW = 200;
    localparam int BW = 400;
    localparam logic [7:0] WK = drs_pkg::WAKE_CMD_DEFAULT;
    logic clk = 1'b0, rst = 1'b1, sleep = 1'b1, slow = 1'b0;
    logic pin_n, drop, busy, blank, creset, nv;
    logic [7:0] nd;
    drs_pkg::drs_cmd_s cmd = '0, fwd;
    drs_pkg::drs_nvm_req_s req;
    drs_pkg::drs_settings_s st;
    int n_errors = 0, n_compared = 0, c;
    always #25 clk = ~clk;
    drs_top #(.CMD_WAIT_CYC(CW), .WAKE_WAIT_CYC(WW), .BLANK_SEQ_CYC(BW)) dut (
        .CORE_CLK(clk), .SYS_RST(rst), .HW_RESET_N_INPUT(pin_n), .SLEEP_IN_MODE(sleep),
        .CMD_IN(cmd), .CMD_FWD(fwd), .CMD_DROP(drop), .NVM_REQ(req), .NVM_RD_VALID(nv),
        .NVM_RD_DATA(nd), .BUSY(busy), .DISPLAY_BLANK(blank), .CTRL_RESET(creset),
        .SETTINGS(st));
    drs_host_mdl host (.clk(clk), .slow(slow), .nvm_req(req), .nvm_valid(nv),
        .nvm_data(nd), .pin_n(pin_n));
    task automatic complete_run();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic wait_idle();
        for (c = 0; busy !== 1'b0 && c < 3000; c++)
            @(negedge clk);
        if (c == 3000)
        begin
            check(1'b0, "busy stuck");
            complete_run();
        end
    endtask
    task automatic send(input logic [7:0] code, input logic fw);
        @(negedge clk);
        cmd = '{1'b1, code};
        @(negedge clk);
        cmd.valid = 1'b0;
        check(fwd.valid === fw && drop === ~fw && (!fw || fwd.code === code), "command");
    endtask
    function automatic drs_pkg::drs_settings_s exp_set(input logic [7:0] b);
        return {b + 8'h03, b + 8'h02, b + 8'h01, b};
    endfunction
    task automatic t_power_on();
        host.base = 8'h40;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        send(8'h2a, 1'b0);
        wait_idle();
        check(c <= CW + 20, "late release");
        check(st === exp_set(8'h40), "settings");
    endtask
    task automatic t_commands();
        send(8'h2a, 1'b1);
        send(WK, 1'b0);
        repeat (WW) @(negedge clk);
        send(WK, 1'b1);
        @(negedge clk);
        check(blank === 1'b0, "still blank");
    endtask
    task automatic t_glitch();
        host.pulse(60, 0);
        repeat (110) @(negedge clk);
        check(creset === 1'b0 && busy === 1'b0, "short low acted");
        host.base = 8'h80;
        slow = 1'b1;
        host.pulse(120, 60);
        check(creset === 1'b1 && blank === 1'b1, "spike ended reset");
        wait_idle();
        check(st === exp_set(8'h80), "no reload");
    endtask
    task automatic t_awake_sleep();
        sleep = 1'b0;
        host.pulse(240, 0);
        wait_idle();
        check(c + 240 >= BW + 96 && c + 240 <= BW + 112, "blank time");
        sleep = 1'b1;
        host.pulse(240, 0);
        wait_idle();
        check(c >= CW + 96 && c <= CW + 120, "sleep release");
    endtask
    initial
    begin
        t_power_on();
        t_commands();
        t_glitch();
        t_awake_sleep();
        complete_run();
    end
endmodule
